// ===== logic/fls_pkg.sv
// Shared constants for the code-protection and serial programming block.
// Assumes a 25 MHz core clock on both ends and a 24-bit serial frame.
package fls_pkg;

    // ******************************************************
    // Clock and timing
    // ******************************************************
    localparam int CLK_FREQ_HZ = 25_000_000;
    localparam int WRITE_TIME_MS = 10;
    localparam int WRITE_CYCLES = WRITE_TIME_MS * (CLK_FREQ_HZ / 1000);
    localparam int POLL_TIMEOUT_CYCLES = 2 * WRITE_CYCLES;
    localparam int TIMER_W = 24;
    localparam logic [1:0] LINK_HALF_LAST = 2'h3;

    // ******************************************************
    // Frame layout and instruction encodings
    // ******************************************************
    localparam logic [4:0] FRAME_LAST = 5'h17;
    localparam logic [4:0] BYTE2_LAST = 5'h0f;
    localparam int ADDR_W = 14;
    localparam int CODE_BYTES = 12288;
    localparam logic [13:0] CODE_TOP = 14'h3000;
    localparam logic [7:0] PREFIX_BYTE = 8'hac;
    localparam logic [7:0] ENABLE_BYTE = 8'h53;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam logic [7:0] ERASE_BYTE = 8'h04;
    localparam logic [2:0] ERASE_SEL = 3'h4;
    localparam logic [2:0] LOCK_SEL = 3'h7;
    localparam logic [1:0] READ_SEL = 2'h1;
    localparam logic [1:0] WRITE_SEL = 2'h2;

    // ******************************************************
    // Protection levels
    // ******************************************************
    localparam logic [2:0] LEVEL_OPEN = 3'h1;
    localparam logic [2:0] LEVEL_NO_PROG = 3'h2;
    localparam logic [2:0] LEVEL_NO_VERIFY = 3'h3;
    localparam logic [2:0] LEVEL_NO_EXT = 3'h4;
    localparam logic [2:0] LOCK_RESET = 3'h0;

    // ******************************************************
    // Programmer register map and command codes
    // ******************************************************
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_ADDR = 4'h4;
    localparam logic [3:0] REG_DATA = 4'h8;
    localparam logic [3:0] REG_STATUS = 4'hc;
    localparam int CTRL_HOLD_BIT = 8;
    localparam logic [2:0] OP_NONE = 3'h0;
    localparam logic [2:0] OP_ENABLE = 3'h1;
    localparam logic [2:0] OP_ERASE = 3'h2;
    localparam logic [2:0] OP_READ = 3'h3;
    localparam logic [2:0] OP_WRITE = 3'h4;
    localparam logic [2:0] OP_LOCK = 3'h5;

    // Lock bits (bit0 = first) to protection level, first missing bit stops it
    function automatic logic [2:0] prot_level(input logic [2:0] lock);
        if (!lock[0]) begin
            return LEVEL_OPEN;
        end else if (!lock[1]) begin
            return LEVEL_NO_PROG;
        end else if (!lock[2]) begin
            return LEVEL_NO_VERIFY;
        end
        return LEVEL_NO_EXT;
    endfunction

    // Six high bits of the first byte, then the whole second byte
    function automatic logic [ADDR_W-1:0] code_addr(input logic [15:0] b12);
        return {b12[15:10], b12[7:0]};
    endfunction

endpackage

// ===== logic/fls_link_if.sv
// Serial programming link between the programmer and the device.
// Assumes the programmer drives the clock and holds the device reset.
`timescale 1ns/10ps
interface fls_link_if;
    logic sck;
    logic mosi;
    logic miso;
    logic rst_hold;

    modport dev (
        input sck,
        input mosi,
        input rst_hold,
        output miso
    );

    modport host (
        output sck,
        output mosi,
        output rst_hold,
        input miso
    );
endinterface

// ===== logic/fls_sync.sv
// Two-stage synchroniser for levels entering a clock domain.
// Assumes multi-bit inputs change rarely and settle before use.
`timescale 1ns/10ps
module fls_sync #(
    parameter int WIDTH = 1
) (
    // Destination clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // Levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;

    // First stage feeds only the second stage
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule

// ===== logic/fls_device.sv
// Device end: lock bits, code array and serial programming decoder.
// Assumes the programmer clocks the link and holds rst_hold high to program.
//
// Behaviour
// - Three nonvolatile lock bits select four levels
// - All lock bits unprogrammed gives no protection
// - First lock bit latches external-access pin at reset
// - Latched access value must match the pin; here a mismatch is not checked, the latched value is used
// - Level two blocks external table reads of code
// - Level two up refuses any code programming
// - Level three also blocks verify readback
// - Level four also blocks external execution
// - Only chip erase clears programmed lock bits; here rstn_in also clears them
// - Enable frame AC 53 xx opens programming
// - Erase frame AC, low bits 100, erases all
// - Address: six high bits, then second byte
// - Read returns addressed byte during third byte
// - Write stores third byte at the address
// - Lock frame AC, zero bit programs lock
// - Write completion shown by data polling
// - Programmer erases before writing non-erased bytes
//
// Chosen here: the Avalon-MM register port and the register addresses.
`timescale 1ns/10ps
module fls_device import fls_pkg::*; #(
    parameter int WRITE_CYCLES_P = WRITE_CYCLES
) (
    // Serial programming link
    fls_link_if.dev link,
    // Core clock and power-on reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // Core pins
    input wire logic ea_pin_in,
    // Protection state towards the core
    output logic [2:0] prot_level_out,
    output logic table_read_block_out,
    output logic program_block_out,
    output logic verify_block_out,
    output logic ext_exec_block_out,
    output logic ea_latched_out,
    output logic write_busy_out
);

    // ******************************************************
    // Link domain: shifter and decode
    // ******************************************************
    logic [23:0] shift_reg;
    logic [23:0] shift_next;
    logic [4:0] cnt_reg;
    logic enabled_reg;
    logic [2:0] lock_reg;
    logic [7:0] mem [CODE_BYTES];
    logic [7:0] out_reg;
    logic miso_reg;
    logic start_tgl_reg;
    logic [7:0] pend_reg;
    logic done_sync;
    logic busy_link;
    logic frame_end;
    logic cmd_ok;
    logic is_enable;
    logic is_erase;
    logic is_lock;
    logic is_write;
    logic [2:0] level;
    logic [ADDR_W-1:0] waddr;
    logic [ADDR_W-1:0] raddr;
    logic [7:0] rbyte;

    assign shift_next = {shift_reg[22:0], link.mosi};
    assign busy_link = start_tgl_reg ^ done_sync;
    assign level = prot_level(lock_reg);
    assign frame_end = (cnt_reg == FRAME_LAST);
    assign waddr = code_addr(shift_next[23:8]);
    assign raddr = code_addr(shift_next[15:0]);
    assign link.miso = miso_reg;

    // Decode of a complete frame; busy cycles drop erase, lock and write commands
    assign is_enable = frame_end && (shift_next[23:16] == PREFIX_BYTE)
        && (shift_next[15:8] == ENABLE_BYTE);
    assign cmd_ok = frame_end && enabled_reg && !busy_link;
    assign is_erase = cmd_ok && (shift_next[23:16] == PREFIX_BYTE)
        && (shift_next[10:8] == ERASE_SEL);
    assign is_lock = cmd_ok && (shift_next[23:16] == PREFIX_BYTE)
        && (shift_next[10:8] == LOCK_SEL);
    assign is_write = cmd_ok && (shift_next[17:16] == WRITE_SEL)
        && (level < LEVEL_NO_PROG) && (waddr < CODE_TOP);

    // Byte offered during the third byte of a read
    always_comb begin
        if (busy_link) begin
            rbyte = ~pend_reg;
        end else if (level >= LEVEL_NO_VERIFY || raddr >= CODE_TOP) begin
            rbyte = ERASED_BYTE;
        end else begin
            rbyte = mem[raddr];
        end
    end

    // Bit counter and shifter, cleared whenever reset is not held
    always_ff @(posedge link.sck or negedge link.rst_hold) begin
        if (!link.rst_hold) begin
            shift_reg <= 24'h00_0000;
            cnt_reg <= 5'h00;
        end else begin
            shift_reg <= shift_next;
            cnt_reg <= frame_end ? 5'h00 : cnt_reg + 5'h01;
        end
    end

    // Enable flag lives only while reset stays high
    always_ff @(posedge link.sck or negedge link.rst_hold) begin
        if (!link.rst_hold) begin
            enabled_reg <= 1'b0;
        end else if (is_enable) begin
            enabled_reg <= 1'b1;
        end
    end

    // Read data leaves MSB first after the second byte
    always_ff @(posedge link.sck or negedge link.rst_hold) begin
        if (!link.rst_hold) begin
            out_reg <= 8'h00;
            miso_reg <= 1'b0;
        end else if (cnt_reg == BYTE2_LAST && enabled_reg
            && shift_next[9:8] == READ_SEL) begin
            miso_reg <= rbyte[7];
            out_reg <= {rbyte[6:0], 1'b0};
        end else begin
            miso_reg <= out_reg[7];
            out_reg <= {out_reg[6:0], 1'b0};
        end
    end

    // Code array; no reset, contents are nonvolatile
    always_ff @(posedge link.sck) begin
        if (is_erase) begin
            for (int i = 0; i < CODE_BYTES; i++) begin
                mem[i] <= ERASED_BYTE;
            end
        end else if (is_write) begin
            mem[waddr] <= shift_next[7:0];
        end
    end

    // Lock bits: set by zeros in a lock frame, cleared by erase or by rstn_in
    always_ff @(posedge link.sck or negedge rstn_in) begin
        if (!rstn_in) begin
            lock_reg <= LOCK_RESET;
        end else if (is_erase) begin
            lock_reg <= LOCK_RESET;
        end else if (is_lock) begin
            lock_reg <= lock_reg | ~{shift_next[13], shift_next[14], shift_next[15]};
        end
    end

    // Each nonvolatile write starts one timed busy period
    always_ff @(posedge link.sck or negedge rstn_in) begin
        if (!rstn_in) begin
            start_tgl_reg <= 1'b0;
            pend_reg <= ERASED_BYTE;
        end else if (is_write) begin
            start_tgl_reg <= ~start_tgl_reg;
            pend_reg <= shift_next[7:0];
        end else if (is_erase || is_lock) begin
            start_tgl_reg <= ~start_tgl_reg;
            pend_reg <= ERASED_BYTE;
        end
    end

    // ******************************************************
    // Core domain: write timer and protection outputs
    // ******************************************************
    logic done_tgl_reg;
    logic start_s;
    logic start_prev_reg;
    logic run_reg;
    logic [TIMER_W-1:0] timer_reg;
    logic ea_s;
    logic hold_s;
    logic [2:0] lock_s;
    logic ea_latch_reg;
    logic [2:0] level_core;

    // The link clock stops between frames, so the write time is counted here
    fls_sync #(.WIDTH(1)) u_done_sync (
        .clk_in(link.sck),
        .rstn_in(rstn_in),
        .async_in(done_tgl_reg),
        .sync_out(done_sync)
    );

    fls_sync #(.WIDTH(6)) u_core_sync (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .async_in({start_tgl_reg, ea_pin_in, link.rst_hold, lock_reg}),
        .sync_out({start_s, ea_s, hold_s, lock_s})
    );

    assign level_core = prot_level(lock_s);

    // Busy timer, answered by toggling the done flag
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            start_prev_reg <= 1'b0;
            run_reg <= 1'b0;
            timer_reg <= '0;
            done_tgl_reg <= 1'b0;
        end else begin
            start_prev_reg <= start_s;
            if (start_s != start_prev_reg) begin
                run_reg <= 1'b1;
                timer_reg <= TIMER_W'(WRITE_CYCLES_P - 1);
            end else if (run_reg && timer_reg == '0) begin
                run_reg <= 1'b0;
                done_tgl_reg <= ~done_tgl_reg;
            end else if (run_reg) begin
                timer_reg <= timer_reg - TIMER_W'(1);
            end
        end
    end

    // Pin level is tracked while reset is held, then frozen
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ea_latch_reg <= 1'b0;
        end else if (hold_s) begin
            ea_latch_reg <= ea_s;
        end
    end

    // Registered protection flags for the core
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            prot_level_out <= LEVEL_OPEN;
            table_read_block_out <= 1'b0;
            program_block_out <= 1'b0;
            verify_block_out <= 1'b0;
            ext_exec_block_out <= 1'b0;
            ea_latched_out <= 1'b0;
            write_busy_out <= 1'b0;
        end else begin
            prot_level_out <= level_core;
            table_read_block_out <= (level_core >= LEVEL_NO_PROG);
            program_block_out <= (level_core >= LEVEL_NO_PROG);
            verify_block_out <= (level_core >= LEVEL_NO_VERIFY);
            ext_exec_block_out <= (level_core == LEVEL_NO_EXT);
            ea_latched_out <= lock_s[0] ? ea_latch_reg : ea_s;
            write_busy_out <= run_reg;
        end
    end

endmodule

// ===== logic/fls_host.sv
// Programmer end: Avalon-MM registers drive three-byte serial frames.
// Assumes one outstanding Avalon request and a device that data-polls.
`timescale 1ns/10ps
module fls_host import fls_pkg::*; #(
    parameter int TIMEOUT_CYCLES_P = POLL_TIMEOUT_CYCLES
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // Avalon-MM slave
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // Serial programming link
    fls_link_if.host link
);

    typedef enum logic [3:0] {
        H_IDLE = 4'b0001,
        H_LOW = 4'b0010,
        H_HIGH = 4'b0100,
        H_CHECK = 4'b1000
    } fls_hst_type;

    // Build one 24-bit instruction frame
    function automatic logic [23:0] make_frame(input logic [2:0] op,
        input logic [ADDR_W-1:0] addr, input logic [7:0] data);
        case (op)
            OP_ENABLE: return {PREFIX_BYTE, ENABLE_BYTE, 8'h00};
            OP_ERASE: return {PREFIX_BYTE, ERASE_BYTE, 8'h00};
            OP_READ: return {addr[13:8], READ_SEL, addr[7:0], 8'h00};
            OP_WRITE: return {addr[13:8], WRITE_SEL, addr[7:0], data};
            OP_LOCK: return {PREFIX_BYTE, ~data[0], ~data[1], ~data[2], 2'b11, LOCK_SEL, 8'h00};
            default: return 24'h00_0000;
        endcase
    endfunction

    fls_hst_type state_reg;
    logic wait_reg;
    logic hold_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [7:0] data_reg;
    logic [7:0] rdata_reg;
    logic [2:0] op_reg;
    logic [23:0] frame_reg;
    logic [23:0] new_frame;
    logic [4:0] bit_reg;
    logic [1:0] ph_reg;
    logic [7:0] rx_reg;
    logic poll_reg;
    logic [TIMER_W-1:0] tmo_reg;
    logic tmo_flag_reg;
    logic refused_reg;
    logic erased_reg;
    logic sck_reg;
    logic mosi_reg;
    logic miso_s;
    logic go;
    logic expect7;

    assign avs_waitrequest_out = wait_reg;
    assign link.sck = sck_reg;
    assign link.mosi = mosi_reg;
    assign link.rst_hold = hold_reg;
    assign go = avs_write_in && !wait_reg && avs_address_in == REG_CTRL
        && avs_writedata_in[2:0] != OP_NONE && state_reg == H_IDLE;
    assign new_frame = make_frame(avs_writedata_in[2:0], addr_reg, data_reg);
    assign expect7 = (op_reg == OP_WRITE) ? data_reg[7] : 1'b1;

    fls_sync #(.WIDTH(1)) u_miso_sync (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .async_in(link.miso),
        .sync_out(miso_s)
    );

    // ******************************************************
    // Avalon slave: one wait cycle, then the access completes
    // ******************************************************
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wait_reg <= 1'b1;
            avs_readdata_out <= 32'h0000_0000;
        end else begin
            wait_reg <= !((avs_read_in || avs_write_in) && wait_reg);
            if (avs_read_in && wait_reg) begin
                if (avs_address_in == REG_CTRL) begin
                    avs_readdata_out <= {23'h00_0000, hold_reg, 5'h00, op_reg};
                end else if (avs_address_in == REG_ADDR) begin
                    avs_readdata_out <= {18'h0_0000, addr_reg};
                end else if (avs_address_in == REG_DATA) begin
                    avs_readdata_out <= {24'h00_0000, rdata_reg};
                end else if (avs_address_in == REG_STATUS) begin
                    avs_readdata_out <= {29'h0000_0000, refused_reg, tmo_flag_reg,
                        state_reg != H_IDLE};
                end else begin
                    avs_readdata_out <= 32'h0000_0000;
                end
            end
        end
    end

    // Register writes land at the completing edge
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            hold_reg <= 1'b0;
            addr_reg <= '0;
            data_reg <= 8'h00;
        end else if (avs_write_in && !wait_reg) begin
            if (avs_address_in == REG_CTRL) begin
                hold_reg <= avs_writedata_in[CTRL_HOLD_BIT];
            end else if (avs_address_in == REG_ADDR) begin
                addr_reg <= avs_writedata_in[ADDR_W-1:0];
            end else if (avs_address_in == REG_DATA) begin
                data_reg <= avs_writedata_in[7:0];
            end
        end
    end

    // ******************************************************
    // Frame engine with data polling
    // ******************************************************
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_reg <= H_IDLE;
            op_reg <= OP_NONE;
            frame_reg <= 24'h00_0000;
            bit_reg <= 5'h00;
            ph_reg <= 2'h0;
            rx_reg <= 8'h00;
            rdata_reg <= 8'h00;
            poll_reg <= 1'b0;
            tmo_reg <= '0;
            tmo_flag_reg <= 1'b0;
            refused_reg <= 1'b0;
            erased_reg <= 1'b0;
            sck_reg <= 1'b0;
            mosi_reg <= 1'b0;
        end else begin
            ph_reg <= ph_reg + 2'h1;
            if (poll_reg) begin
                tmo_reg <= tmo_reg + TIMER_W'(1);
            end
            case (state_reg)
                H_IDLE: begin
                    ph_reg <= 2'h0;
                    // Unerased targets are refused rather than corrupted
                    if (go && avs_writedata_in[2:0] == OP_WRITE && !erased_reg
                        && data_reg != ERASED_BYTE) begin
                        refused_reg <= 1'b1;
                    end else if (go) begin
                        op_reg <= avs_writedata_in[2:0];
                        frame_reg <= new_frame;
                        mosi_reg <= new_frame[23];
                        bit_reg <= 5'h00;
                        poll_reg <= 1'b0;
                        tmo_reg <= '0;
                        tmo_flag_reg <= 1'b0;
                        refused_reg <= 1'b0;
                        erased_reg <= erased_reg || avs_writedata_in[2:0] == OP_ERASE;
                        state_reg <= H_LOW;
                    end
                end
                H_LOW: begin
                    if (ph_reg == LINK_HALF_LAST) begin
                        sck_reg <= 1'b1;
                        rx_reg <= {rx_reg[6:0], miso_s};
                        state_reg <= H_HIGH;
                    end
                end
                H_HIGH: begin
                    if (ph_reg == LINK_HALF_LAST) begin
                        sck_reg <= 1'b0;
                        if (bit_reg == FRAME_LAST) begin
                            state_reg <= H_CHECK;
                        end else begin
                            bit_reg <= bit_reg + 5'h01;
                            frame_reg <= {frame_reg[22:0], 1'b0};
                            mosi_reg <= frame_reg[22];
                            state_reg <= H_LOW;
                        end
                    end
                end
                H_CHECK: begin
                    if (op_reg == OP_READ || op_reg == OP_ENABLE) begin
                        rdata_reg <= rx_reg;
                        state_reg <= H_IDLE;
                    end else if (poll_reg && rx_reg[7] == expect7) begin
                        rdata_reg <= rx_reg;
                        poll_reg <= 1'b0;
                        state_reg <= H_IDLE;
                    end else if (poll_reg && tmo_reg >= TIMER_W'(TIMEOUT_CYCLES_P)) begin
                        tmo_flag_reg <= 1'b1;
                        poll_reg <= 1'b0;
                        state_reg <= H_IDLE;
                    end else begin
                        poll_reg <= 1'b1;
                        frame_reg <= make_frame(OP_READ, addr_reg, 8'h00);
                        mosi_reg <= addr_reg[13];
                        bit_reg <= 5'h00;
                        state_reg <= H_LOW;
                    end
                end
                default: state_reg <= H_IDLE;
            endcase
        end
    end

endmodule

// ===== testbench/fls_asserts.sv
// Checker for the serial link between programmer and device.
// Assumes the programmer makes sck from clk_in.
`timescale 1ns/10ps
module fls_asserts (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // Link
    input wire logic sck,
    input wire logic mosi,
    input wire logic miso,
    input wire logic rst_hold
);
    // ****
    // Helpers
    // ****
    logic [4:0] rise_reg;
    logic [3:0] low_reg;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    // Rises per frame, wrapping after the 24th
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rise_reg <= 5'h00;
        end else if ($rose(sck)) begin
            rise_reg <= (rise_reg == 5'h17) ? 5'h00 : rise_reg + 5'h01;
        end
    end
    // Low run length, saturating so idles need no wide counter
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            low_reg <= 4'h0;
        end else begin
            low_reg <= sck ? 4'h0 : low_reg + {3'h0, low_reg != 4'hf};
        end
    end
    sequence s_high_run;
        sck [*4] ##1 !sck;
    endsequence
    a_sck_high: assert property ($rose(sck) |-> s_high_run)
        else $error("sck high time wrong");
    a_sck_low: assert property ($fell(sck) |-> !sck [*4])
        else $error("sck low time wrong");
    a_rise_spacing: assert property ($rose(sck) && rise_reg != 5'h17 |-> ##8 $rose(sck))
        else $error("frame bit missing");
    a_frame_whole: assert property (low_reg == 4'h8 |-> rise_reg == 5'h00)
        else $error("frame not 24 bits");
    a_mosi_hold: assert property (sck |-> $stable(mosi))
        else $error("mosi moved while sck high");
    a_miso_launch: assert property ($changed(miso) |-> sck || !rst_hold)
        else $error("miso moved off sck rise");
    a_miso_cleared: assert property (!rst_hold |-> !miso)
        else $error("miso driven in link reset");
    a_sck_gated: assert property (sck |-> rst_hold)
        else $error("sck runs without hold");
endmodule

// ===== testbench/flash_lock_serial_programming_test.sv
// Bench: programmer and device joined by the link, driven over Avalon-MM.
// Assumes short busy and timeout counts so the run stays brief.
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin error_cnt++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module flash_lock_serial_programming_test;
    import fls_pkg::*;
    logic clk_in = 1'b0;
    logic rstn_in = 1'b1;
    logic ea_pin_in = 1'b0;
    logic [3:0] avs_address_in = 4'h0;
    logic avs_read_in = 1'b0;
    logic avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h0000_0000;
    logic [31:0] avs_readdata_out;
    logic avs_waitrequest_out;
    logic [2:0] prot_level_out;
    logic [4:0] blk;
    logic ea_latched_out;
    logic [31:0] rd;
    logic [31:0] seed = 32'h0000_003c; // Seed 60
    logic [13:0] a;
    logic [7:0] d;
    int error_cnt = 0, comparisons = 0;
    fls_link_if link ();
    always #20 clk_in = ~clk_in;
    fls_device #(.WRITE_CYCLES_P(600)) fls_device_i (.link(link.dev), .clk_in(clk_in),
        .rstn_in(rstn_in), .ea_pin_in(ea_pin_in), .prot_level_out(prot_level_out),
        .table_read_block_out(blk[4]), .program_block_out(blk[3]), .verify_block_out(blk[2]),
        .ext_exec_block_out(blk[1]), .ea_latched_out(ea_latched_out), .write_busy_out(blk[0]));
    fls_host #(.TIMEOUT_CYCLES_P(3000)) fls_host_i (.clk_in(clk_in), .rstn_in(rstn_in),
        .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
        .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
        .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
        .link(link.host));
    fls_asserts fls_asserts_i (.clk_in(clk_in), .rstn_in(rstn_in), .sck(link.sck),
        .mosi(link.mosi), .miso(link.miso), .rst_hold(link.rst_hold));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    // Level, the four block flags and an idle busy flag from the lock bits
    function automatic logic [7:0] exp_prot(input logic [2:0] lb);
        logic [2:0] v;
        v = !lb[0] ? 3'h1 : !lb[1] ? 3'h2 : !lb[2] ? 3'h3 : 3'h4;
        return {v, v >= 3'h2, v >= 3'h2, v >= 3'h3, v == 3'h4, 1'b0};
    endfunction
    // One Avalon access; held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [3:0] ad, input logic [31:0] wd);
        @(posedge clk_in);
        avs_write_in <= wr;
        avs_read_in <= !wr;
        avs_address_in <= ad;
        avs_writedata_in <= wd;
        do @(posedge clk_in); while (avs_waitrequest_out !== 1'b0);
        rd = avs_readdata_out;
        avs_write_in <= 1'b0;
        avs_read_in <= 1'b0;
    endtask
    // Start an operation with hold high, wait for idle, then fetch DATA
    task automatic op(input logic [2:0] c, input logic [13:0] ad, input logic [31:0] wd);
        bus(1'b1, REG_ADDR, {18'h0_0000, ad});
        bus(1'b1, REG_DATA, wd);
        bus(1'b1, REG_CTRL, {23'h00_0000, 1'b1, 5'h00, c});
        do bus(1'b0, REG_STATUS, 32'h0000_0000); while (rd[0] !== 1'b0);
        bus(1'b0, REG_DATA, 32'h0000_0000);
    endtask
    task automatic close_out();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Watchdog sized well above the expected run
    initial begin
        #(40 * 90000);
        error_cnt++;
        close_out();
    end
    initial begin
        rstn_in <= 1'b0; // A real falling edge resets the flops clocked by the link
        repeat (20) @(posedge clk_in);
        rstn_in <= 1'b1;
        ea_pin_in <= 1'b1;
        `CHK({prot_level_out, blk}, exp_prot(3'h0))
        op(OP_READ, 14'h0123, 32'h0000_0000);
        `CHK(rd[7:0], 8'h00)
        op(OP_ENABLE, 14'h0000, 32'h0000_0000);
        op(OP_WRITE, 14'h0010, 32'h0000_0012);
        bus(1'b0, REG_STATUS, 32'h0000_0000);
        `CHK(rd[2], 1'b1)
        op(OP_ERASE, CODE_TOP, 32'h0000_0000);
        for (int i = 0; i < 6; i++) begin
            seed = xs(seed);
            a = {i[2:0], seed[10:0]};
            d = seed[31:24];
            op(OP_WRITE, a, {24'h00_0000, d});
            op(OP_READ, a, 32'h0000_0000);
            `CHK({blk[0], rd[7:0]}, {1'b0, d})
        end
        for (int k = 1; k < 4; k++) begin
            op(OP_LOCK, CODE_TOP, (32'h0000_0001 << k) - 32'h0000_0001);
            `CHK({prot_level_out, blk}, exp_prot(3'((1 << k) - 1)))
            op(OP_WRITE, a, {24'h00_0000, d ^ 8'h01});
            op(OP_READ, a, 32'h0000_0000);
            `CHK(rd[7:0], (k == 1) ? d : 8'hff)
        end
        // Drop hold so the latch freezes, then move the pin under it
        bus(1'b1, REG_CTRL, 32'h0000_0000);
        repeat (8) @(posedge clk_in);
        ea_pin_in <= 1'b0;
        repeat (8) @(posedge clk_in);
        `CHK(ea_latched_out, 1'b1)
        op(OP_READ, a, 32'h0000_0000);
        `CHK(rd[7:0], 8'h00)
        `CHK(ea_latched_out, 1'b0)
        op(OP_ENABLE, 14'h0000, 32'h0000_0000);
        op(OP_ERASE, CODE_TOP, 32'h0000_0000);
        `CHK({prot_level_out, blk}, exp_prot(3'h0))
        op(OP_READ, a, 32'h0000_0000);
        `CHK(rd[7:0], 8'hff)
        close_out();
    end
endmodule
